/* File: pmt_timer.sv */
// match based pulse width timer with an axi4-lite register slave
//
// Notes on behaviour
// - seven match registers feed six outputs; the first is single edge, the rest single or double.
// - match zero sets the cycle length by returning the count to zero.
// - single edge outputs rise on the period match unless held low.
// - a single edge output uses one own match register for its fall.
// - a double edge output uses its own match register and the one below it.
// - double edge order sets the pulse polarity, rise first is positive.
// - each double edge position is free within the cycle.
// - each match may flag an interrupt and keep, stop or reset the count.
// - in pulse mode written match values act only once released, at a cycle boundary.
// - with pulse mode off the block is a plain match timer.
// - a 32-bit counter advances under a 32-bit prescaler.
// - the count runs on the clock or on edges of a chosen capture input.
// - all outputs share one period, set in whole counts.
`timescale 1ns/1ps
module pmt_timer
  import pmt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCAP-1:0] capIn,
  output logic [NOUT-1:0] pwmOut,
  output logic [NOUT-1:0] pwmOe,
  output logic matchIrq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= OFF_RELEASE);
  endfunction

  function automatic logic [31:0] mergeLanes(input logic [31:0] old,
                                             input logic [31:0] val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pmt_ctrl_t ctrl_ff;
  pmt_cntcfg_t cntCfg_ff;
  logic [31:0] tcCnt_ff;
  logic [31:0] pcCnt_ff;
  logic [31:0] preLim_ff;
  logic [MACT_W-1:0] mact_ff;
  logic [OUTCFG_W-1:0] outCfg_ff;
  logic [NMATCH-1:0] release_ff;
  logic [NMATCH-1:0] flag_ff;
  logic matchIrq_ff;
  logic [NCAP-1:0] capPrev_ff;
  logic [NMATCH-1:0][31:0] mrShadow_ff;
  logic [NMATCH-1:0][31:0] mrAct_ff;

  logic awGot_ff;
  logic wGot_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // ---------------------------------------------------------------
  // write channel decode
  // ---------------------------------------------------------------
  logic doWr;
  logic [31:0] mrgWord;
  logic wrFlag;
  logic wrCtrl;
  logic wrCount;
  logic wrPreLim;
  logic wrMact;
  logic wrCntCfg;
  logic wrOutCfg;
  logic wrRelease;
  logic [NMATCH-1:0] wrMatch;
  logic [31:0] mactMrg;

  assign s_axi_awready = !awGot_ff && !bvalid_ff;
  assign s_axi_wready = !wGot_ff && !bvalid_ff;
  assign doWr = awGot_ff && wGot_ff;
  assign mrgWord = mergeLanes(RST_WORD, wData_ff, wStrb_ff);
  assign wrFlag = doWr && (awAddr_ff == OFF_FLAG);
  assign wrCtrl = doWr && (awAddr_ff == OFF_CTRL);
  assign wrCount = doWr && (awAddr_ff == OFF_COUNT);
  assign wrPreLim = doWr && (awAddr_ff == OFF_PRELIM);
  assign wrMact = doWr && (awAddr_ff == OFF_MACT);
  assign wrCntCfg = doWr && (awAddr_ff == OFF_CNTCFG);
  assign wrOutCfg = doWr && (awAddr_ff == OFF_OUTCFG);
  assign wrRelease = doWr && (awAddr_ff == OFF_RELEASE);
  assign mactMrg = mergeLanes(32'(mact_ff), wData_ff, wStrb_ff);

  // ---------------------------------------------------------------
  // count source and prescaler
  // ---------------------------------------------------------------
  logic selNow;
  logic selPrev;
  logic tick;
  logic run;
  logic preWrap;
  logic incEv;

  assign selNow = capIn[cntCfg_ff.capSel];
  assign selPrev = capPrev_ff[cntCfg_ff.capSel];
  assign tick = (cntCfg_ff.mode == CM_TIMER) ? 1'b1 :
                (cntCfg_ff.mode == CM_RISE) ? (selNow && !selPrev) :
                (cntCfg_ff.mode == CM_FALL) ? (!selNow && selPrev) :
                (selNow != selPrev);
  assign run = ctrl_ff.cntEna && !ctrl_ff.cntRst;
  assign preWrap = pcCnt_ff == preLim_ff;
  assign incEv = run && tick && preWrap;

  // ---------------------------------------------------------------
  // match compare and actions
  // ---------------------------------------------------------------
  logic [NMATCH-1:0] hit;
  logic [NMATCH-1:0] irqBits;
  logic [NMATCH-1:0] rstBits;
  logic [NMATCH-1:0] stopBits;
  logic [NMATCH-1:0] apply;
  logic anyRst;
  logic anyStop;
  logic cycleEnd;

  for (genvar i = 0; i < NMATCH; i++) begin : g_match
    localparam logic [7:0] MOFF = OFF_MATCH0 + 8'(4 * i);
    assign wrMatch[i] = doWr && (awAddr_ff == MOFF);
    assign hit[i] = incEv && (tcCnt_ff == mrAct_ff[i]);
    assign irqBits[i] = mact_ff[MACT_STRIDE*i + MACT_IRQ];
    assign stopBits[i] = mact_ff[MACT_STRIDE*i + MACT_STOP];
    // the period match always resets while pulse mode is on
    if (i == 0) begin : g_per
      assign rstBits[i] = mact_ff[MACT_RST] || ctrl_ff.pwmEna;
    end else begin : g_oth
      assign rstBits[i] = mact_ff[MACT_STRIDE*i + MACT_RST];
    end
    // in timer mode writes act at once, in pulse mode at cycle end
    assign apply[i] = ctrl_ff.pwmEna ? (cycleEnd && release_ff[i])
                                     : 1'b1;
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        mrShadow_ff[i] <= RST_WORD;
        mrAct_ff[i] <= RST_WORD;
      end else begin
        if (wrMatch[i]) begin
          mrShadow_ff[i] <= mergeLanes(mrShadow_ff[i], wData_ff, wStrb_ff);
        end
        if (apply[i]) begin
          mrAct_ff[i] <= mrShadow_ff[i];
        end
      end
    end
  end

  assign anyRst = |(hit & rstBits);
  assign anyStop = |(hit & stopBits);
  assign cycleEnd = hit[0] && ctrl_ff.pwmEna;

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  logic [31:0] nxt_tcCnt;
  logic [31:0] nxt_pcCnt;
  logic [NMATCH-1:0] nxt_flag;
  logic [NMATCH-1:0] nxt_release;
  logic [NMATCH-1:0] flagClr;

  assign nxt_pcCnt = ctrl_ff.cntRst ? RST_WORD :
                     !(run && tick) ? pcCnt_ff :
                     preWrap ? RST_WORD : pcCnt_ff + 32'h0000_0001;
  assign nxt_tcCnt = ctrl_ff.cntRst ? RST_WORD :
                     wrCount ? mergeLanes(tcCnt_ff, wData_ff, wStrb_ff) :
                     !incEv ? tcCnt_ff :
                     anyRst ? RST_WORD :
                     anyStop ? tcCnt_ff : tcCnt_ff + 32'h0000_0001;
  assign flagClr = wrFlag ? mrgWord[NMATCH-1:0] : '0;
  // a new match event outranks a clear in the same cycle
  assign nxt_flag = (flag_ff & ~flagClr) | (hit & irqBits);
  // a fresh release outranks the hardware clear of an applied one
  assign nxt_release = (release_ff & ~(apply & {NMATCH{ctrl_ff.pwmEna}}))
                     | (wrRelease ? mrgWord[NMATCH-1:0] : '0);

  // ---------------------------------------------------------------
  // counter and control registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tcCnt_ff <= RST_WORD;
      pcCnt_ff <= RST_WORD;
      capPrev_ff <= '0;
      flag_ff <= '0;
      matchIrq_ff <= 1'b0;
      release_ff <= '0;
    end else begin
      tcCnt_ff <= nxt_tcCnt;
      pcCnt_ff <= nxt_pcCnt;
      capPrev_ff <= capIn;
      flag_ff <= nxt_flag;
      matchIrq_ff <= |nxt_flag;
      release_ff <= nxt_release;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= '0;
      cntCfg_ff <= '0;
      preLim_ff <= RST_WORD;
      mact_ff <= '0;
      outCfg_ff <= '0;
    end else begin
      if (wrCtrl) begin
        ctrl_ff <= pmt_ctrl_t'(mrgWord[2:0]);
      end else if (anyStop) begin
        ctrl_ff.cntEna <= 1'b0;
      end
      if (wrCntCfg) begin
        cntCfg_ff <= pmt_cntcfg_t'(mrgWord[2:0]);
      end
      if (wrPreLim) begin
        preLim_ff <= mergeLanes(preLim_ff, wData_ff, wStrb_ff);
      end
      if (wrMact) begin
        mact_ff <= mactMrg[MACT_W-1:0];
      end
      if (wrOutCfg) begin
        outCfg_ff <= mrgWord[OUTCFG_W-1:0] & OUTCFG_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // pulse outputs
  // ---------------------------------------------------------------
  for (genvar k = 0; k < NOUT; k++) begin : g_out
    logic dbl;
    // output k+1: double edge takes its rise from the match below it
    assign dbl = outCfg_ff[k+1];
    pmt_edge_cell u_cell (
      .sys_clk(sys_clk),
      .rst(rst),
      .pwmEna(ctrl_ff.pwmEna),
      .setEv(dbl ? hit[k] : hit[0]),
      .clrEv(hit[k+1]),
      .pwmOut(pwmOut[k])
    );
    assign pwmOe[k] = outCfg_ff[OUTCFG_OE_BASE + k + 1];
  end

  assign matchIrq = matchIrq_ff;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic [31:0] rdVal;
  logic [2:0] mIdx;

  assign mIdx = 3'((s_axi_araddr - OFF_MATCH0) >> 2);

  always_comb begin
    rdVal = RST_WORD;
    if (s_axi_araddr == OFF_FLAG) begin
      rdVal = 32'(flag_ff);
    end else if (s_axi_araddr == OFF_CTRL) begin
      rdVal = 32'(ctrl_ff);
    end else if (s_axi_araddr == OFF_COUNT) begin
      rdVal = tcCnt_ff;
    end else if (s_axi_araddr == OFF_PRELIM) begin
      rdVal = preLim_ff;
    end else if (s_axi_araddr == OFF_PRECNT) begin
      rdVal = pcCnt_ff;
    end else if (s_axi_araddr == OFF_MACT) begin
      rdVal = 32'(mact_ff);
    end else if (s_axi_araddr >= OFF_MATCH0 &&
                 s_axi_araddr <= OFF_MATCH6 && isMapped(s_axi_araddr)) begin
      rdVal = mrShadow_ff[mIdx];
    end else if (s_axi_araddr == OFF_CNTCFG) begin
      rdVal = 32'(cntCfg_ff);
    end else if (s_axi_araddr == OFF_OUTCFG) begin
      rdVal = 32'(outCfg_ff);
    end else if (s_axi_araddr == OFF_RELEASE) begin
      rdVal = 32'(release_ff);
    end
  end

  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awGot_ff <= 1'b0;
      wGot_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= RST_WORD;
      wStrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awGot_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wGot_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWr) begin
        awGot_ff <= 1'b0;
        wGot_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= isMapped(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= RST_WORD;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= rdVal;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence timerHeld;
    !ctrl_ff.pwmEna [*2];
  endsequence

  sequence periodReset;
    hit[0] && rstBits[0] && !wrCount && !ctrl_ff.cntRst;
  endsequence

  period_reset_a: assert property (periodReset |=> tcCnt_ff == 0)
    else $error("period match did not zero the count");
  prescale_wrap_a: assert property (run && tick && preWrap |=>
      pcCnt_ff == 0)
    else $error("prescaler did not restart at its limit");
  count_step_a: assert property (incEv && !anyRst && !anyStop && !wrCount
      |=> tcCnt_ff == $past(tcCnt_ff) + 32'h0000_0001)
    else $error("count did not advance on prescaler wrap");
  stop_match_a: assert property (anyStop && !wrCtrl |=>
      !ctrl_ff.cntEna)
    else $error("stop match left the counter running");
  match_flag_a: assert property (hit[1] && irqBits[1] |=>
      flag_ff[1] && matchIrq)
    else $error("match event lost its flag");
  release_apply_a: assert property (cycleEnd && release_ff[1] &&
      !wrMatch[1] |=> mrAct_ff[1] == $past(mrShadow_ff[1]))
    else $error("released value not applied at cycle end");
  hold_value_a: assert property (ctrl_ff.pwmEna && !cycleEnd |=>
      $stable(mrAct_ff))
    else $error("match value changed mid cycle");
  timer_direct_a: assert property (timerHeld |->
      mrAct_ff == $past(mrShadow_ff))
    else $error("timer mode did not use written values at once");
  count_source_a: assert property (cntCfg_ff.mode != CM_TIMER && !tick
      && !ctrl_ff.cntRst |=> $stable(pcCnt_ff))
    else $error("prescaler moved without a capture edge");
  write_resp_a: assert property (doWr |=> s_axi_bvalid)
    else $error("write took no response");

endmodule // pmt_timer

/* File: pmt_pkg.sv */
// constants and types shared by the match based pwm timer
package pmt_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned DW = 32;
  localparam int unsigned NMATCH = 7;
  localparam int unsigned NOUT = 6;
  localparam int unsigned NCAP = 2;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_FLAG = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_PRELIM = 8'h0C;
  localparam logic [7:0] OFF_PRECNT = 8'h10;
  localparam logic [7:0] OFF_MACT = 8'h14;
  localparam logic [7:0] OFF_MATCH0 = 8'h18;
  localparam logic [7:0] OFF_MATCH6 = 8'h30;
  localparam logic [7:0] OFF_CNTCFG = 8'h34;
  localparam logic [7:0] OFF_OUTCFG = 8'h38;
  localparam logic [7:0] OFF_RELEASE = 8'h3C;
  localparam logic [7:0] OFF_STEP = 8'h04;

  // ---------------------------------------------------------------
  // field positions and masks
  // ---------------------------------------------------------------
  localparam int unsigned MACT_IRQ = 0;
  localparam int unsigned MACT_RST = 1;
  localparam int unsigned MACT_STOP = 2;
  localparam int unsigned MACT_STRIDE = 3;
  localparam int unsigned MACT_W = NMATCH * MACT_STRIDE;
  localparam int unsigned CFG_SEL_BIT = 2;
  localparam int unsigned OUTCFG_OE_BASE = 8;
  localparam int unsigned OUTCFG_W = 15;
  localparam logic [14:0] OUTCFG_MASK = 15'h7E7C;

  // ---------------------------------------------------------------
  // reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CM_TIMER = 2'h0,
    CM_RISE = 2'h1,
    CM_FALL = 2'h2,
    CM_BOTH = 2'h3
  } pmt_cmode_t;

  typedef struct packed {
    logic pwmEna;
    logic cntRst;
    logic cntEna;
  } pmt_ctrl_t;

  typedef struct packed {
    logic capSel;
    pmt_cmode_t mode;
  } pmt_cntcfg_t;

endpackage

/* File: pmt_edge_cell.sv */
// one pulse output: set and clear events drive a held level
`timescale 1ns/1ps
module pmt_edge_cell
  import pmt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pwmEna,
  input wire logic setEv,
  input wire logic clrEv,
  output logic pwmOut
);

  logic pwmOut_ff;
  logic nxt_pwmOut;

  // clear wins a tie, so an edge placed on the period gives constant low
  assign nxt_pwmOut = !pwmEna ? 1'b0 :
                      clrEv ? 1'b0 :
                      setEv ? 1'b1 : pwmOut_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwmOut_ff <= 1'b0;
    end else begin
      pwmOut_ff <= nxt_pwmOut;
    end
  end

  assign pwmOut = pwmOut_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  cell_rise_a: assert property (pwmEna && setEv && !clrEv |=> pwmOut)
    else $error("output did not rise on its set event");
  cell_fall_a: assert property (pwmEna && clrEv |=> !pwmOut)
    else $error("output did not fall on its clear event");
  cell_idle_a: assert property (!pwmEna |=> !pwmOut)
    else $error("output moved while pulse mode is off");

endmodule // pmt_edge_cell

/* File: pmt_load_model.sv */
// pulse load model: measures high widths and the period seen at the pins
`timescale 1ns/1ps
module pmt_load_model
  import pmt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [NOUT-1:0] pwmOut,
  input wire logic [NOUT-1:0] pwmOe,
  output logic [NOUT-1:0][7:0] highW,
  output logic [7:0] periodW
);
  // ---------------------------------------------------------------
  // width and period meters
  // ---------------------------------------------------------------
  logic [NOUT-1:0][7:0] run_ff;
  logic [NOUT-1:0] last_ff;
  logic [7:0] per_ff;
  wire [NOUT-1:0] seen = pwmOut & pwmOe;

  // a pin whose enable is low is not driven, so the load sees nothing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_ff <= '0;
      last_ff <= '0;
      per_ff <= 8'h00;
      highW <= '0;
      periodW <= 8'h00;
    end else begin
      last_ff <= seen;
      per_ff <= per_ff + 8'h01;
      if (seen[0] && !last_ff[0]) begin
        per_ff <= 8'h01;
        periodW <= per_ff;
      end
      for (int i = 0; i < NOUT; i++) begin
        run_ff[i] <= last_ff[i] ? run_ff[i] + 8'h01 : 8'h01;
        if (!seen[i] && last_ff[i]) begin
          highW[i] <= run_ff[i];
        end
      end
    end
  end
endmodule // pmt_load_model

/* File: match_based_pwm_timer_tb.sv */
// self-checking bench for the match based pwm timer
`timescale 1ns/1ps
module match_based_pwm_timer_tb
  import pmt_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awA = 8'h00;
  logic [7:0] arA = 8'h00;
  logic [31:0] wD = 32'h0000_0000;
  logic [3:0] wS = 4'h0;
  logic awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0;
  logic [NCAP-1:0] capIn = '0;
  logic awRdy, wRdy, bV, arRdy, rV, irq;
  logic [1:0] bRs, rRs, rs;
  logic [31:0] rDat, rv;
  logic [NOUT-1:0] pwmOut, pwmOe;
  logic [NOUT-1:0][7:0] highW;
  logic [7:0] periodW;
  logic [2:0] cfgs [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
  logic [31:0] exps [4] = '{32'h0000_0003, 32'h0000_0003,
                            32'h0000_0006, 32'h0000_0003};
  int n_mismatch = 0;
  int n_checks = 0;
  int pin;

  always #12.5 sys_clk = ~sys_clk;

  pmt_timer dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awA),
    .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
    .s_axi_wstrb(wS), .s_axi_wvalid(wV), .s_axi_wready(wRdy),
    .s_axi_bresp(bRs), .s_axi_bvalid(bV), .s_axi_bready(bR),
    .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
    .s_axi_rdata(rDat), .s_axi_rresp(rRs), .s_axi_rvalid(rV),
    .s_axi_rready(rR), .capIn(capIn), .pwmOut(pwmOut), .pwmOe(pwmOe),
    .matchIrq(irq));

  pmt_load_model load (.sys_clk(sys_clk), .rst(rst), .pwmOut(pwmOut),
    .pwmOe(pwmOe), .highW(highW), .periodW(periodW));

  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  // each channel is judged and released at the rising edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    awA <= a;
    wD <= d;
    wS <= 4'hF;
    awV <= 1'b1;
    wV <= 1'b1;
    bR <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (awV && awRdy) awV <= 1'b0;
      if (wV && wRdy) wV <= 1'b0;
      if (bV && bR) begin
        rs = bRs;
        bR <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    arA <= a;
    arV <= 1'b1;
    rR <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arV && arRdy) arV <= 1'b0;
      if (rV && rR) begin
        rv = rDat;
        rs = rRs;
        rR <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic endTest(input string s);
    $display("test %0s done", s);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFF_FLAG);
    chk(rv, RST_WORD);
    wr(8'h05, 32'h0000_0007);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    rd(OFF_CTRL);
    chk(rv, RST_WORD);
    rd(8'h40);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    chk(rv, RST_WORD);
    endTest("reset");
    wr(OFF_PRELIM, 32'h0000_0002);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    wr(OFF_MATCH0 + OFF_STEP, 32'h0000_0005);
    wr(OFF_MACT, 32'h0000_0028);
    wr(OFF_CTRL, 32'h0000_0001);
    repeat (40) @(posedge sys_clk);
    rd(OFF_COUNT);
    chk(rv, 32'h0000_0005);
    rd(OFF_CTRL);
    chk(rv, RST_WORD);
    rd(OFF_FLAG);
    chk(rv, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(OFF_FLAG, 32'h0000_0002);
    rd(OFF_FLAG);
    chk(rv, RST_WORD);
    @(negedge sys_clk);
    chk({31'h0, irq}, RST_WORD);
    wr(OFF_COUNT, 32'h0000_0010);
    rd(OFF_COUNT);
    chk(rv, 32'h0000_0010);
    endTest("stop");
    // match 2 resets at 3, so the stop match at 5 is never reached
    wr(OFF_MATCH0 + 8'h08, 32'h0000_0003);
    wr(OFF_MACT, 32'h0000_00E8);
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0001);
    repeat (40) @(posedge sys_clk);
    rd(OFF_FLAG);
    chk(rv, 32'h0000_0004);
    rd(OFF_CTRL);
    chk(rv, 32'h0000_0001);
    endTest("reset match");
    wr(OFF_MACT, RST_WORD);
    wr(OFF_PRELIM, RST_WORD);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL, 32'h0000_0002);
      wr(OFF_CNTCFG, {29'h0, cfgs[i]});
      wr(OFF_CTRL, 32'h0000_0001);
      // the unselected pin also toggles and must not count
      for (int k = 0; k < 5; k++) begin
        pin = (k < 3) ? int'(cfgs[i][2]) : int'(!cfgs[i][2]);
        @(posedge sys_clk);
        capIn[pin] <= 1'b1;
        repeat (2) @(posedge sys_clk);
        capIn[pin] <= 1'b0;
        repeat (2) @(posedge sys_clk);
      end
      rd(OFF_COUNT);
      chk(rv, exps[i]);
    end
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_CNTCFG, RST_WORD);
    endTest("counter");
    wr(OFF_MATCH0, 32'h0000_0009);
    wr(OFF_MATCH0 + OFF_STEP, 32'h0000_0003);
    wr(OFF_MATCH0 + 8'h08, 32'h0000_0008);
    wr(OFF_MATCH0 + 8'h0C, 32'h0000_0001);
    wr(OFF_OUTCFG, 32'h0000_0A08);
    wr(OFF_CTRL, 32'h0000_0005);
    repeat (40) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({24'h0, periodW}, 32'h0000_000A);
    chk({24'h0, highW[0]}, 32'h0000_0004);
    chk({24'h0, highW[2]}, 32'h0000_0003);
    chk({26'h0, pwmOe}, 32'h0000_0005);
    wr(OFF_MATCH0 + OFF_STEP, 32'h0000_0006);
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({24'h0, highW[0]}, 32'h0000_0004);
    wr(OFF_RELEASE, 32'h0000_0002);
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({24'h0, highW[0]}, 32'h0000_0007);
    rd(OFF_RELEASE);
    chk(rv, RST_WORD);
    endTest("pulse");
    wr(OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({26'h0, pwmOut}, RST_WORD);
    endTest("plain");
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end
endmodule // match_based_pwm_timer_tb
